// [src/rhlw_cfg.svh]
// Constants for the regulator hold latch and windowed watchdog block
`ifndef RHLW_CFG_SVH
`define RHLW_CFG_SVH

// Clock
`define RHLW_CLK_PERIOD_NS     8

// Reset pulse duration options in ns, nominal
`define RHLW_TRP_D0_NS         35000
`define RHLW_TRP_D1_NS         3125000
`define RHLW_TRP_D2_NS         12500000
`define RHLW_TRP_D3_NS         50000000
`define RHLW_TRP_D4_NS         200000000

// Cycle counts, rounded up to whole cycles
`define RHLW_TRP_D0_CYC        ((`RHLW_TRP_D0_NS + `RHLW_CLK_PERIOD_NS - 1) / `RHLW_CLK_PERIOD_NS)
`define RHLW_TRP_D1_CYC        ((`RHLW_TRP_D1_NS + `RHLW_CLK_PERIOD_NS - 1) / `RHLW_CLK_PERIOD_NS)
`define RHLW_TRP_D2_CYC        ((`RHLW_TRP_D2_NS + `RHLW_CLK_PERIOD_NS - 1) / `RHLW_CLK_PERIOD_NS)
`define RHLW_TRP_D3_CYC        ((`RHLW_TRP_D3_NS + `RHLW_CLK_PERIOD_NS - 1) / `RHLW_CLK_PERIOD_NS)
`define RHLW_TRP_D4_CYC        ((`RHLW_TRP_D4_NS + `RHLW_CLK_PERIOD_NS - 1) / `RHLW_CLK_PERIOD_NS)
`define RHLW_TRP_SEL_DEFAULT   2

// Window ratio shifts
`define RHLW_SHIFT_RATIO_8     5'd3
`define RHLW_SHIFT_RATIO_16    5'd4
`define RHLW_SHIFT_RATIO_64    5'd6

// Register offsets
`define RHLW_OFS_STATUS        12'h000
`define RHLW_OFS_SLOW_PERIOD   12'h004
`define RHLW_OFS_FAULT         12'h008
`define RHLW_OFS_WD_COUNT      12'h00c

// Reset values
`define RHLW_SLOW_PERIOD_RST   32'h0001_0000
`define RHLW_FAULT_RST         2'h0

// Status field positions
`define RHLW_ST_OUT_ON_BIT     0
`define RHLW_ST_RESET_BIT      1
`define RHLW_ST_LATCH_LSB      2
`define RHLW_ST_SEL_LSB        4
`define RHLW_ST_WD_DIS_BIT     6

// Fault field positions
`define RHLW_FLT_FAST_BIT      0
`define RHLW_FLT_SLOW_BIT      1

`endif

// [src/rhlw_pkg.sv]
// Types for the regulator hold latch and windowed watchdog block
package rhlw_pkg;

  typedef enum logic [1:0] {
    rhlw_latch_initial = 2'b00,
    rhlw_latch_turn_on = 2'b01,
    rhlw_latch_hold    = 2'b10
  } rhlw_latch_t;

  typedef enum logic [1:0] {
    rhlw_ratio_8        = 2'b00,
    rhlw_ratio_16       = 2'b01,
    rhlw_ratio_disabled = 2'b10,
    rhlw_ratio_64       = 2'b11
  } rhlw_ratio_t;

endpackage

// [src/rhlw_hold_latch.sv]
// On/off latch for the primary regulator output
`timescale 1ns/1ps
`default_nettype none

module rhlw_hold_latch (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               primary_turn_on_request,
  input  wire logic               self_latch_request_n,
  output var  logic               regulator_on,
  output var  rhlw_pkg::rhlw_latch_t state
);

  rhlw_pkg::rhlw_latch_t next_state;
  logic                  next_regulator_on;

  always_comb begin
    next_state = state;
    case (state)
      rhlw_pkg::rhlw_latch_initial: begin
        if (primary_turn_on_request) begin
          next_state = rhlw_pkg::rhlw_latch_turn_on;
        end
      end
      rhlw_pkg::rhlw_latch_turn_on: begin
        if (!primary_turn_on_request) begin
          next_state = rhlw_pkg::rhlw_latch_initial;
        end else if (!self_latch_request_n) begin
          next_state = rhlw_pkg::rhlw_latch_hold;
        end
      end
      rhlw_pkg::rhlw_latch_hold: begin
        if (!primary_turn_on_request && self_latch_request_n) begin
          next_state = rhlw_pkg::rhlw_latch_initial;
        end else if (primary_turn_on_request && self_latch_request_n) begin
          next_state = rhlw_pkg::rhlw_latch_turn_on;
        end
      end
      default: begin
        next_state = rhlw_pkg::rhlw_latch_initial;
      end
    endcase
    // Output stays on in hold unless turn-on is low and self-latch is high
    next_regulator_on = (next_state != rhlw_pkg::rhlw_latch_initial);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state        <= rhlw_pkg::rhlw_latch_initial;
      regulator_on <= 1'b0;
    end else begin
      state        <= next_state;
      regulator_on <= next_regulator_on;
    end
  end

endmodule // rhlw_hold_latch

`default_nettype wire

// [src/rhlw_reset_stretch.sv]
// Stretches a fault trigger into an active-low reset pulse of fixed length
`timescale 1ns/1ps
`default_nettype none

module rhlw_reset_stretch #(
  parameter int unsigned CYCLES = 4375
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic trigger,
  output var  logic reset_n,
  output var  logic active
);

  logic [31:0] count;
  logic [31:0] next_count;
  logic        next_reset_n;
  logic        next_active;

  always_comb begin
    next_count   = count;
    next_active  = active;
    if (active) begin
      if (count == CYCLES[31:0] - 32'h0000_0001) begin
        next_active = 1'b0;
        next_count  = 32'h0000_0000;
      end else begin
        next_count = count + 32'h0000_0001;
      end
    end else if (trigger) begin
      next_active = 1'b1;
      next_count  = 32'h0000_0000;
    end
    next_reset_n = ~next_active;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count   <= 32'h0000_0000;
      active  <= 1'b0;
      reset_n <= 1'b1;
    end else begin
      count   <= next_count;
      active  <= next_active;
      reset_n <= next_reset_n;
    end
  end

endmodule // rhlw_reset_stretch

`default_nettype wire

// [src/rhlw_top.sv]
// Regulator hold latch, windowed watchdog and APB register slave
//
// Summary of operation
// - Turn-on request low keeps the primary output off from the initial state.
// - Turn-on request high turns the primary output on, self-latch ignored.
// - Self-latch pulled low while turn-on is high latches the output on.
// - Latched output stays on after turn-on drops, while self-latch stays low.
// - Self-latch high with turn-on low switches off and returns to initial.
// - Select 00 ratio 8, 01 ratio 16, 11 ratio 64, 10 disables watchdog.
// - Reset pulse length is a build option among five nominal durations.
// - Strobe edges too close or too far apart assert reset for its duration.
// - Strobe edges are ignored while reset is asserted.
// - Watchdog timer clears on reset and restarts only after release.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rhlw_cfg.svh"

module rhlw_top #(
  parameter int unsigned RESET_TIMEOUT_SEL = `RHLW_TRP_SEL_DEFAULT,
  parameter int unsigned TRP_D0_CYCLES     = `RHLW_TRP_D0_CYC,
  parameter int unsigned TRP_D1_CYCLES     = `RHLW_TRP_D1_CYC,
  parameter int unsigned TRP_D2_CYCLES     = `RHLW_TRP_D2_CYC,
  parameter int unsigned TRP_D3_CYCLES     = `RHLW_TRP_D3_CYC,
  parameter int unsigned TRP_D4_CYCLES     = `RHLW_TRP_D4_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // Regulator control pins
  input  wire logic        primary_turn_on_request,
  input  wire logic        self_latch_request_n,
  output var  logic        primary_regulator_output,
  // Watchdog pins
  input  wire logic        window_ratio_select_a,
  input  wire logic        window_ratio_select_b,
  input  wire logic        watchdog_strobe_input,
  output var  logic        supervisory_reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr
);

  // Reset pulse length picked at build time
  localparam int unsigned RESET_PULSE_CYCLES =
    (RESET_TIMEOUT_SEL == 0) ? TRP_D0_CYCLES :
    (RESET_TIMEOUT_SEL == 1) ? TRP_D1_CYCLES :
    (RESET_TIMEOUT_SEL == 3) ? TRP_D3_CYCLES :
    (RESET_TIMEOUT_SEL == 4) ? TRP_D4_CYCLES : TRP_D2_CYCLES;

  rhlw_pkg::rhlw_latch_t latch_state;
  rhlw_pkg::rhlw_ratio_t ratio_sel;

  logic        reset_active;
  logic        wd_fault;

  logic        strobe_prev;
  logic        next_strobe_prev;
  logic [31:0] wd_count;
  logic [31:0] next_wd_count;
  logic [31:0] slow_period;
  logic [31:0] next_slow_period;
  logic [31:0] fast_period;
  logic [4:0]  ratio_shift;
  logic        wd_disabled;
  logic        wd_running;
  logic        strobe_edge;
  logic        fast_fault;
  logic        slow_fault;

  logic [1:0]  fault_flags;
  logic [1:0]  next_fault_flags;

  logic        apb_setup;
  logic        apb_access;
  logic        apb_write;
  logic        addr_ok;
  logic [31:0] read_word;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;

  // Regulator on/off latch
  rhlw_hold_latch u_hold_latch (
    .clk                     (clk),
    .rst                     (rst),
    .primary_turn_on_request (primary_turn_on_request),
    .self_latch_request_n    (self_latch_request_n),
    .regulator_on            (primary_regulator_output),
    .state                   (latch_state)
  );

  // Reset pulse generator
  rhlw_reset_stretch #(
    .CYCLES (RESET_PULSE_CYCLES)
  ) u_reset_stretch (
    .clk     (clk),
    .rst     (rst),
    .trigger (wd_fault),
    .reset_n (supervisory_reset_n),
    .active  (reset_active)
  );

  // Ratio decode
  always_comb begin
    ratio_sel   = rhlw_pkg::rhlw_ratio_t'({window_ratio_select_a, window_ratio_select_b});
    wd_disabled = 1'b0;
    case (ratio_sel)
      rhlw_pkg::rhlw_ratio_8: begin
        ratio_shift = `RHLW_SHIFT_RATIO_8;
      end
      rhlw_pkg::rhlw_ratio_16: begin
        ratio_shift = `RHLW_SHIFT_RATIO_16;
      end
      rhlw_pkg::rhlw_ratio_64: begin
        ratio_shift = `RHLW_SHIFT_RATIO_64;
      end
      rhlw_pkg::rhlw_ratio_disabled: begin
        ratio_shift = `RHLW_SHIFT_RATIO_8;
        wd_disabled = 1'b1;
      end
      default: begin
        ratio_shift = `RHLW_SHIFT_RATIO_8;
      end
    endcase
    fast_period = slow_period >> ratio_shift;
  end

  // Windowed watchdog
  always_comb begin
    wd_running       = ~reset_active & ~wd_disabled;
    // Edges seen during reset are dropped
    strobe_edge      = wd_running & (watchdog_strobe_input != strobe_prev);
    fast_fault       = strobe_edge & (wd_count < fast_period);
    slow_fault       = wd_running & (wd_count > slow_period);
    wd_fault         = fast_fault | slow_fault;
    next_strobe_prev = watchdog_strobe_input;
    if (!wd_running || wd_fault) begin
      next_wd_count = 32'h0000_0000;
    end else if (strobe_edge) begin
      next_wd_count = 32'h0000_0001;
    end else begin
      next_wd_count = wd_count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      strobe_prev <= 1'b0;
      wd_count    <= 32'h0000_0000;
    end else begin
      strobe_prev <= next_strobe_prev;
      wd_count    <= next_wd_count;
    end
  end

  // APB decode
  always_comb begin
    apb_setup  = psel & ~penable;
    apb_access = psel & penable & pready;
    addr_ok    = (paddr == `RHLW_OFS_STATUS) | (paddr == `RHLW_OFS_SLOW_PERIOD) |
                 (paddr == `RHLW_OFS_FAULT) | (paddr == `RHLW_OFS_WD_COUNT);
    apb_write  = apb_access & pwrite & ~pslverr;
    read_word  = 32'h0000_0000;
    case (paddr)
      `RHLW_OFS_STATUS: begin
        read_word[`RHLW_ST_OUT_ON_BIT]                     = primary_regulator_output;
        read_word[`RHLW_ST_RESET_BIT]                      = reset_active;
        read_word[`RHLW_ST_LATCH_LSB + 1:`RHLW_ST_LATCH_LSB] = latch_state;
        read_word[`RHLW_ST_SEL_LSB + 1:`RHLW_ST_SEL_LSB]   = ratio_sel;
        read_word[`RHLW_ST_WD_DIS_BIT]                     = wd_disabled;
      end
      `RHLW_OFS_SLOW_PERIOD: begin
        read_word = slow_period;
      end
      `RHLW_OFS_FAULT: begin
        read_word[1:0] = fault_flags;
      end
      `RHLW_OFS_WD_COUNT: begin
        read_word = wd_count;
      end
      default: begin
        read_word = 32'h0000_0000;
      end
    endcase
    next_pready  = apb_setup;
    next_pslverr = apb_setup & ~addr_ok;
    next_prdata  = (apb_setup & ~pwrite & addr_ok) ? read_word : 32'h0000_0000;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Software registers
  always_comb begin
    next_slow_period = slow_period;
    next_fault_flags = fault_flags;
    if (apb_write && paddr == `RHLW_OFS_SLOW_PERIOD) begin
      next_slow_period = pwdata;
    end
    if (apb_write && paddr == `RHLW_OFS_FAULT) begin
      next_fault_flags = fault_flags & ~pwdata[1:0];
    end
    // A new fault wins over a clear in the same cycle
    if (fast_fault) begin
      next_fault_flags[`RHLW_FLT_FAST_BIT] = 1'b1;
    end
    if (slow_fault) begin
      next_fault_flags[`RHLW_FLT_SLOW_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      slow_period <= `RHLW_SLOW_PERIOD_RST;
      fault_flags <= `RHLW_FAULT_RST;
    end else begin
      slow_period <= next_slow_period;
      fault_flags <= next_fault_flags;
    end
  end

endmodule // rhlw_top

`default_nettype wire

// [tb/rhlw_top_asserts.sv]
// Checker for the hold latch, watchdog and register slave
`timescale 1ns/1ps
`default_nettype none
module rhlw_top_asserts #(
  parameter int unsigned PULSE_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        primary_turn_on_request,
  input wire logic        self_latch_request_n,
  input wire logic        primary_regulator_output,
  input wire logic        window_ratio_select_a,
  input wire logic        window_ratio_select_b,
  input wire logic        supervisory_reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr
);
  wire         ton = primary_turn_on_request;
  wire         sln = self_latch_request_n;
  wire         on  = primary_regulator_output;
  wire         rn  = supervisory_reset_n;
  int unsigned low_cnt;
  int unsigned next_low_cnt;
  // Counts sampled low cycles of the reset pulse
  always_comb next_low_cnt = (rst || rn) ? 0 : low_cnt + 1;
  always_ff @(posedge clk) low_cnt <= next_low_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_off_release: assert property (!ton && sln |=> !on) else $error("output stayed on");
  a_rise_cause: assert property ($rose(on) |-> $past(ton)) else $error("output rose alone");
  a_on_request: assert property (ton |=> on) else $error("output not turned on");
  a_hold_keeps: assert property (ton && !sln ##1 !ton && !sln |=> on) else $error("hold lost");
  a_pulse_width: assert property ($rose(rn) && !$past(rst) |-> low_cnt == PULSE_CYCLES)
    else $error("reset pulse width wrong");
  a_disabled_quiet: assert property ((window_ratio_select_a && !window_ratio_select_b)[*3] |-> !$fell(rn))
    else $error("reset while watchdog disabled");
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_err_unmapped: assert property (pready && paddr > 12'h00c |-> pslverr) else $error("no error on unmapped");
  c_fault: cover property ($fell(rn));
  c_hold: cover property (ton && !sln ##1 !ton && !sln);
  c_err: cover property (pready && pslverr);
endmodule // rhlw_top_asserts
bind rhlw_top rhlw_top_asserts #(
  .PULSE_CYCLES (RESET_PULSE_CYCLES)
) rhlw_top_asserts_inst (
  .clk                      (clk),
  .rst                      (rst),
  .primary_turn_on_request  (primary_turn_on_request),
  .self_latch_request_n     (self_latch_request_n),
  .primary_regulator_output (primary_regulator_output),
  .window_ratio_select_a    (window_ratio_select_a),
  .window_ratio_select_b    (window_ratio_select_b),
  .supervisory_reset_n      (supervisory_reset_n),
  .psel                     (psel),
  .penable                  (penable),
  .paddr                    (paddr),
  .pready                   (pready),
  .pslverr                  (pslverr)
);
`default_nettype wire

// [tb/rhlw_mcu_model.sv]
// Microprocessor model driving the request pins and the watchdog strobe
`timescale 1ns/1ps
`default_nettype none
module rhlw_mcu_model (
  input  wire logic clk,
  output var  logic primary_turn_on_request,
  output var  logic self_latch_request_n,
  output var  logic watchdog_strobe_input
);
  initial begin
    primary_turn_on_request = 1'b0;
    self_latch_request_n    = 1'b1;
    watchdog_strobe_input   = 1'b0;
  end
  // Drives turn-on and self-latch together on one clock edge; latch arming calls it with turn-on high
  task automatic pins(input logic t, input logic l);
    @(posedge clk);
    primary_turn_on_request <= t;
    self_latch_request_n    <= l;
  endtask
  task automatic toggle(input int gap, input int cnt);
    repeat (cnt) begin
      repeat (gap) @(posedge clk);
      watchdog_strobe_input <= ~watchdog_strobe_input;
    end
  endtask
endmodule // rhlw_mcu_model
`default_nettype wire

// [tb/tb_rhlw_top.sv]
// Self-checking bench for the hold latch and windowed watchdog block
`timescale 1ns/1ps
`default_nettype none
module tb_rhlw_top;
  localparam int RESET_PULSE_DURATION = 20;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic        primary_turn_on_request, self_latch_request_n, primary_regulator_output;
  logic        window_ratio_select_a, window_ratio_select_b, watchdog_strobe_input;
  logic        supervisory_reset_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int          fail_count, comparisons, n;
  int          fast [3] = '{8, 4, 1};
  logic [1:0]  pat [3] = '{2'b00, 2'b01, 2'b11};
  rhlw_top #(
    .RESET_TIMEOUT_SEL (0),
    .TRP_D0_CYCLES     (RESET_PULSE_DURATION)
  ) rhlw_top_inst (
    .clk                      (clk),
    .rst                      (rst),
    .primary_turn_on_request  (primary_turn_on_request),
    .self_latch_request_n     (self_latch_request_n),
    .primary_regulator_output (primary_regulator_output),
    .window_ratio_select_a    (window_ratio_select_a),
    .window_ratio_select_b    (window_ratio_select_b),
    .watchdog_strobe_input    (watchdog_strobe_input),
    .supervisory_reset_n      (supervisory_reset_n),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr)
  );
  rhlw_mcu_model rhlw_mcu_model_inst (
    .clk                     (clk),
    .primary_turn_on_request (primary_turn_on_request),
    .self_latch_request_n    (self_latch_request_n),
    .watchdog_strobe_input   (watchdog_strobe_input)
  );
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      $display("Error at %0t: ready got %h expected %h", $time, pready, 1'b1);
      fail_count++;
      tally_and_finish();
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic pin(input logic t, input logic l, input logic x);
    rhlw_mcu_model_inst.pins(t, l);
    repeat (2) @(posedge clk);
    chk({31'h0, primary_regulator_output}, {31'h0, x});
  endtask
  task automatic wait_rn(input logic v, input int b);
    n = 0;
    while (supervisory_reset_n !== v && n < b) begin
      @(posedge clk);
      n++;
    end
    if (n >= b) begin
      $display("Error at %0t: reset output got %h expected %h", $time, supervisory_reset_n, v);
      fail_count++;
      tally_and_finish();
    end
  endtask
  // Waits for a fault pulse, strobes during it and measures its width
  task automatic pulse();
    wait_rn(1'b0, 100);
    fork
      rhlw_mcu_model_inst.toggle(3, 2);
      wait_rn(1'b1, 100);
    join
    chk(n, RESET_PULSE_DURATION);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {window_ratio_select_a, window_ratio_select_b} = 2'b00;
    fail_count = 0;
    comparisons = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0001_0000);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, e} | q, 32'h1);
    $display("test registers done");
    pin(1'b0, 1'b0, 1'b0);
    pin(1'b1, 1'b1, 1'b1);
    pin(1'b1, 1'b0, 1'b1);
    pin(1'b0, 1'b0, 1'b1);
    rd(12'h000, 32'h9);
    pin(1'b0, 1'b1, 1'b0);
    pin(1'b0, 1'b0, 1'b0);
    pin(1'b1, 1'b1, 1'b1);
    rd(12'h000, 32'h5);
    pin(1'b0, 1'b0, 1'b0);
    $display("test latch done");
    for (int i = 0; i < 3; i++) begin
      window_ratio_select_a <= 1'b1;
      window_ratio_select_b <= 1'b0;
      apb(1'b1, 12'h004, 32'h40);
      rd(12'h000, 32'h60);
      rd(12'h00c, 32'h0);
      window_ratio_select_a <= pat[i][1];
      window_ratio_select_b <= pat[i][0];
      rhlw_mcu_model_inst.toggle(20, 4);
      rhlw_mcu_model_inst.toggle(fast[i], 1);
      repeat (5) @(posedge clk);
      chk({31'h0, supervisory_reset_n}, 32'h1);
      if (fast[i] > 1) begin
        // A legal strobe first, so the short gap is timed from an accepted edge
        rhlw_mcu_model_inst.toggle(20, 1);
        rhlw_mcu_model_inst.toggle(fast[i] / 2, 1);
        pulse();
        repeat (50) @(posedge clk);
        chk({31'h0, supervisory_reset_n}, 32'h1);
      end
      pulse();
      window_ratio_select_a <= 1'b1;
      window_ratio_select_b <= 1'b0;
      rd(12'h008, fast[i] > 1 ? 32'h3 : 32'h2);
      apb(1'b1, 12'h008, 32'h3);
      rd(12'h008, 32'h0);
      $display("test ratio %0d done", i);
    end
    tally_and_finish();
  end
endmodule // tb_rhlw_top
`default_nettype wire
